//--- src/useq_pkg.sv
// shared constants and types for the microprogram address sequencer
package useq_pkg;
    localparam int ADDR_W = 9;
    localparam int SLICE_W = 12;
    localparam int STACK_DEPTH = 4;
    localparam int WORD_W = 40;
    localparam int BC_LSB = 17;
    localparam int BC_MSB = 19;
    localparam int NRA_LSB = 23;
    localparam int NRA_MSB = 31;
    localparam int SLV_EN_BIT = 16;
    localparam int IRQ_N = 5;
    localparam logic [2:0] PRIO_IDLE = 3'h7;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 9'h000;
    localparam logic [SLICE_W-1:0] SLICE_ZERO = 12'h000;

    typedef enum logic [2:0] {
        BC_INC = 3'b000,
        BC_JMP = 3'b001,
        BC_JT = 3'b010,
        BC_JF = 3'b011,
        BC_CALL = 3'b100,
        BC_RT = 3'b101,
        BC_RF = 3'b110,
        BC_RET = 3'b111
    } branch_e;

    // adder, stack and output source selects with carry
    typedef struct packed {
        logic [1:0] add_sel;
        logic [1:0] stk_sel;
        logic [1:0] out_sel;
        logic carry;
    } seq_select_code_s;

    localparam logic [1:0] ADD_BA = 2'b00;
    localparam logic [1:0] ADD_A = 2'b01;
    localparam logic [1:0] ADD_B = 2'b10;
    localparam logic [1:0] ADD_C = 2'b11;
    localparam logic [1:0] STK_HOLD = 2'b00;
    localparam logic [1:0] STK_LOAD = 2'b01;
    localparam logic [1:0] STK_POP = 2'b10;
    localparam logic [1:0] STK_PUSH = 2'b11;
    localparam logic [1:0] OUT_DIN = 2'b00;
    localparam logic [1:0] OUT_ADD = 2'b01;
    localparam logic [1:0] OUT_STK = 2'b10;
    localparam logic [1:0] OUT_REG = 2'b11;
endpackage

//--- src/branch_decoder.sv
// branch decoder: branch field, test bit and trap into select code
`timescale 1ns/100ps
module branch_decoder
    import useq_pkg::*;
(
    input wire logic [2:0] branch_field,
    input wire logic test_bit,
    input wire logic trap,
    output seq_select_code_s sel
);
    function automatic seq_select_code_s mk(input logic [1:0] a, input logic [1:0] s,
                                            input logic [1:0] o, input logic c);
        seq_select_code_s r;
        r.add_sel = a;
        r.stk_sel = s;
        r.out_sel = o;
        r.carry = c;
        return r;
    endfunction

    always_comb
    begin
        sel = mk(ADD_B, STK_HOLD, OUT_ADD, 1'b1);
        if (trap)
            // trap code: push current address, load data input
            sel = mk(ADD_B, STK_PUSH, OUT_DIN, 1'b0);
        else
        begin
            case (branch_e'(branch_field))
                BC_INC: sel = mk(ADD_B, STK_HOLD, OUT_ADD, 1'b1);
                BC_JMP: sel = mk(ADD_A, STK_HOLD, OUT_ADD, 1'b0);
                BC_JT: sel = test_bit ? mk(ADD_A, STK_HOLD, OUT_ADD, 1'b0)
                                      : mk(ADD_B, STK_HOLD, OUT_ADD, 1'b1);
                BC_JF: sel = test_bit ? mk(ADD_B, STK_HOLD, OUT_ADD, 1'b1)
                                      : mk(ADD_A, STK_HOLD, OUT_ADD, 1'b0);
                BC_CALL: sel = mk(ADD_B, STK_PUSH, OUT_DIN, 1'b1);
                BC_RT: sel = test_bit ? mk(ADD_C, STK_POP, OUT_STK, 1'b0)
                                      : mk(ADD_A, STK_HOLD, OUT_ADD, 1'b0);
                BC_RF: sel = test_bit ? mk(ADD_A, STK_HOLD, OUT_ADD, 1'b0)
                                      : mk(ADD_C, STK_POP, OUT_STK, 1'b0);
                BC_RET: sel = mk(ADD_C, STK_POP, OUT_STK, 1'b0);
                default: sel = mk(ADD_B, STK_HOLD, OUT_ADD, 1'b1);
            endcase
        end
    end
endmodule

//--- src/microsequencer_trap_control.sv
// microprogram address sequencer with slave, interrupt and reset traps
`timescale 1ns/100ps
// Operation
// - output nine address bits from twelve-bit generator
// - power reset clears address register asynchronously
// - branch bits 17-19, next address 23-31
// - test bit picks conditional branch outcome
// - no trap passes next-address field unchanged
// - decoder forms selects from branch, test, trap
// - register and stack update on rising edge
// - microword bit 16 enables slave traps
// - slave access raises trap, flag, pushes address
// - trap forces bit 01 zero, fills 02-05
// - slave trap bits 06-09 from read, address
// - slave reads 0F0-0F7, writes 0F8-0FF
// - error interrupts unmaskable, preempt operation
// - priority abort, timeout, bus, write, timer
// - interrupt conditions registered before priority encoding
// - encoder gives code, disabled by slave flag
// - vectors 000,010,020,030,040
// - interrupt trap zeros 06-09, pushes, loads vector
// - trap suppresses datapath byte clocks
// - return pops saved address, refetches instruction
// - abort from power fail, power reset, I/O reset
// - branch codes per sequencer function table
// - four-deep stack, push drops, pop duplicates
// - trap gives one fixed decoder code
module microsequencer_trap_control
    import useq_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
)
(
    input wire logic sequencer_clock_n,
    input wire logic arst_n,
    input wire logic [WORD_W-1:0] microword_lines,
    input wire logic test_bit,
    input wire logic slave_req_a,
    input wire logic slave_req_b_n,
    input wire logic host_read,
    input wire logic [2:0] host_addr_low_bits,
    input wire logic power_reset_n,
    input wire logic power_fail_warn_n,
    input wire logic io_reset_n,
    input wire logic master_timeout_n,
    input wire logic bus_error_n,
    input wire logic write_timing_err_n,
    input wire logic cmd_timer_expired_n,
    output logic [ADDR_W-1:0] micro_addr_out,
    output logic slave_active,
    output logic slave_reject,
    output logic irq_trap_n,
    output logic [2:0] irq_priority_code,
    output logic datapath_clk_en,
    output logic bus_abort_latched_n
);
    // the sequencer_clock_n port is the dedicated lightly loaded clock copy
    wire logic ref_clk = sequencer_clock_n;

    // power reset also clears the output register directly
    wire logic clr_n = arst_n & power_reset_n;

    logic [IRQ_N-1:0] irq_raw;
    logic [IRQ_N-1:0] irq_s1_r;
    logic [IRQ_N-1:0] irq_s2_r;
    logic [IRQ_N-1:0] irq_q_r;
    logic [1:0] slv_s1_r;
    logic [1:0] slv_s2_r;
    logic [3:0] host_s1_r;
    logic [3:0] host_s2_r;

    always_comb
    begin
        irq_raw[0] = ~power_fail_warn_n | ~power_reset_n | ~io_reset_n;
        irq_raw[1] = ~master_timeout_n;
        irq_raw[2] = ~bus_error_n;
        irq_raw[3] = ~write_timing_err_n;
        irq_raw[4] = ~cmd_timer_expired_n;
    end

    // two-stage capture of asynchronous conditions
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_s1_r <= '0;
            irq_s2_r <= '0;
            slv_s1_r <= 2'h0;
            slv_s2_r <= 2'h0;
            host_s1_r <= 4'h0;
            host_s2_r <= 4'h0;
        end
        else
        begin
            irq_s1_r <= irq_raw;
            irq_s2_r <= irq_s1_r;
            slv_s1_r <= {slave_req_a, ~slave_req_b_n};
            slv_s2_r <= slv_s1_r;
            host_s1_r <= {host_read, host_addr_low_bits};
            host_s2_r <= host_s1_r;
        end
    end

    logic [2:0] bc;
    logic [ADDR_W-1:0] next_addr_field;
    logic slv_en;
    always_comb
    begin
        bc = microword_lines[BC_MSB:BC_LSB];
        next_addr_field = microword_lines[NRA_MSB:NRA_LSB];
        slv_en = microword_lines[SLV_EN_BIT];
    end

    // trap state: a taken trap blocks the next request for one cycle
    logic trap_r;
    logic trap_nxt;
    logic slave_active_r;
    logic slave_active_nxt;
    logic reject_r;
    logic reject_nxt;
    logic [2:0] prio_r;
    logic [2:0] prio_nxt;
    logic [IRQ_N-1:0] irq_q_nxt;
    // slave read and register bits held for the trap cycle; pins move on
    logic [3:0] host_q_r;
    logic [3:0] host_q_nxt;
    logic [2:0] enc;
    logic irq_any;
    logic slv_req;
    logic trap;

    function automatic logic [2:0] prio_enc(input logic [IRQ_N-1:0] v);
        logic [2:0] code;
        code = PRIO_IDLE;
        for (int i = IRQ_N - 1; i >= 0; i--)
        begin
            if (v[i])
                code = 3'(i);
        end
        return code;
    endfunction

    always_comb
    begin
        irq_q_nxt = irq_s2_r;
        slv_req = slv_s2_r[1] & slv_s2_r[0];
        irq_any = |irq_q_r;
        enc = prio_enc(irq_q_r);
        slave_active_nxt = slv_req & slv_en & ~trap_r;
        reject_nxt = slv_req & ~slv_en;
        host_q_nxt = slave_active_nxt ? host_s2_r : host_q_r;
        // slave flag disables the encoder
        prio_nxt = slave_active_nxt ? PRIO_IDLE : enc;
        // interrupts cannot be masked by the microword
        trap_nxt = ~trap_r & (slave_active_nxt | irq_any);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_q_r <= '0;
            trap_r <= 1'b0;
            slave_active_r <= 1'b0;
            reject_r <= 1'b0;
            prio_r <= PRIO_IDLE;
            host_q_r <= 4'h0;
        end
        else
        begin
            irq_q_r <= irq_q_nxt;
            trap_r <= trap_nxt;
            slave_active_r <= slave_active_nxt;
            reject_r <= reject_nxt;
            prio_r <= prio_nxt;
            host_q_r <= host_q_nxt;
        end
    end

    assign trap = trap_r;

    // next-address multiplexers
    logic [ADDR_W-1:0] din;
    always_comb
    begin
        din = next_addr_field;
        if (trap)
        begin
            din[8] = 1'b0;
            din[7:4] = {slave_active_r, prio_r};
            if (slave_active_r)
                din[3:0] = {~host_q_r[3], host_q_r[2:0]};
            else
                din[3:0] = 4'h0;
        end
    end

    seq_select_code_s sel;
    branch_decoder u_dec (
        .branch_field(bc),
        .test_bit(test_bit),
        .trap(trap),
        .sel(sel)
    );

    // address generator: adder, stack, output register
    logic [SLICE_W-1:0] out_r;
    logic [SLICE_W-1:0] out_nxt;
    logic [SLICE_W-1:0] stk_r [DEPTH];
    logic [SLICE_W-1:0] stk_nxt [DEPTH];
    logic [SLICE_W-1:0] din_w;
    logic [SLICE_W-1:0] sum;

    always_comb
    begin
        din_w = {3'h0, din};
        case (sel.add_sel)
            ADD_BA: sum = out_r + din_w + SLICE_W'(sel.carry);
            ADD_A: sum = din_w + SLICE_W'(sel.carry);
            ADD_B: sum = out_r + SLICE_W'(sel.carry);
            default: sum = SLICE_W'(sel.carry);
        endcase
        for (int i = 0; i < DEPTH; i++)
            stk_nxt[i] = stk_r[i];
        case (sel.stk_sel)
            STK_LOAD: stk_nxt[0] = sum;
            STK_POP:
            begin
                for (int i = 0; i < DEPTH - 1; i++)
                    stk_nxt[i] = stk_r[i+1];
            end
            STK_PUSH:
            begin
                stk_nxt[0] = sum;
                for (int i = 1; i < DEPTH; i++)
                    stk_nxt[i] = stk_r[i-1];
            end
            default: ;
        endcase
        case (sel.out_sel)
            OUT_DIN: out_nxt = din_w;
            OUT_ADD: out_nxt = sum;
            OUT_STK: out_nxt = stk_r[0];
            default: out_nxt = out_r;
        endcase
    end

    always_ff @(posedge ref_clk or negedge clr_n)
    begin
        if (!clr_n)
            out_r <= SLICE_ZERO;
        else
            out_r <= out_nxt;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                stk_r[i] <= SLICE_ZERO;
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
                stk_r[i] <= stk_nxt[i];
        end
    end

    always_comb
    begin
        micro_addr_out = out_r[ADDR_W-1:0];
        slave_active = slave_active_r;
        slave_reject = reject_r;
        irq_trap_n = ~(trap_r & ~slave_active_r);
        irq_priority_code = prio_r;
        datapath_clk_en = ~trap_r;
        bus_abort_latched_n = ~irq_q_r[0];
    end

    // enabled slave request seen, then trap cycle with slave flag
    sequence slv_seen_q;
        slv_req && slv_en && !trap_r;
    endsequence
    sequence slv_taken_q;
        slave_active_r && trap_r && !datapath_clk_en;
    endsequence

    AST_TRAP_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        trap_r |=> !trap_r) else $error("trap held over two cycles");
    AST_CLK_SUPPRESS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        slave_active_r || !irq_trap_n |-> !datapath_clk_en)
        else $error("byte clocks not suppressed");
    AST_TRAP_CODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        trap_r |-> sel.stk_sel == STK_PUSH && sel.out_sel == OUT_DIN && !sel.carry)
        else $error("trap code wrong");
    AST_TRAP_PUSH: assert property (@(posedge ref_clk) disable iff (!clr_n)
        trap_r |=> stk_r[0] == $past(out_r)) else $error("trap did not push");
    AST_IRQ_VECTOR: assert property (@(posedge ref_clk) disable iff (!clr_n)
        trap_r && !slave_active_r |=> micro_addr_out == {1'b0, 1'b0, $past(prio_r), 4'h0})
        else $error("interrupt vector wrong");
    AST_SLAVE_VECTOR: assert property (@(posedge ref_clk) disable iff (!clr_n)
        trap_r && slave_active_r |=> micro_addr_out[8:4] == 5'h0F)
        else $error("slave vector wrong");
    AST_SLAVE_GATED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        slave_active_r |-> prio_r == PRIO_IDLE) else $error("encoder not disabled");
    AST_ABORT_FIRST: assert property (@(posedge ref_clk) disable iff (!arst_n)
        irq_q_r[0] && !slave_active_nxt |=> prio_r == 3'h0)
        else $error("abort not highest");
    AST_POWER_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !power_reset_n |-> out_r == SLICE_ZERO) else $error("power reset not cleared");
    AST_INC: assert property (@(posedge ref_clk) disable iff (!clr_n)
        clr_n && !trap_r && bc == BC_INC |=> out_r == $past(out_r) + 12'h001)
        else $error("increment wrong");
    AST_SLAVE_TRAP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        slv_seen_q |=> slv_taken_q) else $error("slave trap not taken");
endmodule

//--- test/host_bus_model.sv
// host processor and power supply stand-in for the sequencer bench
`timescale 1ns/100ps
module host_bus_model
(
    input wire logic clk,
    output logic slave_req_a,
    output logic slave_req_b_n,
    output logic host_read,
    output logic [2:0] host_addr_low_bits,
    output logic [5:0] fault_n
);
    initial
    begin
        slave_req_a = 1'b0;
        slave_req_b_n = 1'b1;
        host_read = 1'b1;
        host_addr_low_bits = 3'h5;
        fault_n = 6'h3F;
    end

    // one-cycle request; idx 6 is a slave access, else a fault line
    task automatic pulse(input int idx, input logic rd, input logic [2:0] a);
        @(posedge clk);
        if (idx == 6)
        begin
            slave_req_a <= 1'b1;
            slave_req_b_n <= 1'b0;
            host_read <= rd;
            host_addr_low_bits <= a;
        end
        else
            fault_n[idx] <= 1'b0;
        @(posedge clk);
        slave_req_a <= 1'b0;
        slave_req_b_n <= 1'b1;
        host_read <= ~rd;
        host_addr_low_bits <= ~a;
        fault_n <= 6'h3F;
    endtask
endmodule

//--- test/test_microsequencer_trap_control.sv
// self-checking bench for the microsequencer trap control
`timescale 1ns/100ps
module test_microsequencer_trap_control;
    import useq_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic power_reset_n = 1'b1;
    logic [WORD_W-1:0] word = '0;
    logic test_bit = 1'b0;
    logic slave_req_a, slave_req_b_n, host_read, slave_active, slave_reject;
    logic irq_trap_n, datapath_clk_en, bus_abort_latched_n;
    logic [2:0] host_addr_low_bits, irq_priority_code;
    logic [5:0] fault_n;
    logic [ADDR_W-1:0] micro_addr_out, cur, exp_pend;
    logic [ADDR_W-1:0] stk [4] = '{default: '0};
    logic pend = 1'b0;
    logic [31:0] seed = 32'h76A2;
    logic [31:0] v;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    host_bus_model partner (.clk(ref_clk), .slave_req_a(slave_req_a),
        .slave_req_b_n(slave_req_b_n), .host_read(host_read),
        .host_addr_low_bits(host_addr_low_bits), .fault_n(fault_n));

    microsequencer_trap_control uut (.sequencer_clock_n(ref_clk), .arst_n(arst_n),
        .microword_lines(word), .test_bit(test_bit), .slave_req_a(slave_req_a),
        .slave_req_b_n(slave_req_b_n), .host_read(host_read),
        .host_addr_low_bits(host_addr_low_bits), .power_reset_n(power_reset_n),
        .power_fail_warn_n(fault_n[0]), .io_reset_n(fault_n[1]),
        .master_timeout_n(fault_n[2]), .bus_error_n(fault_n[3]),
        .write_timing_err_n(fault_n[4]), .cmd_timer_expired_n(fault_n[5]),
        .micro_addr_out(micro_addr_out), .slave_active(slave_active),
        .slave_reject(slave_reject), .irq_trap_n(irq_trap_n),
        .irq_priority_code(irq_priority_code), .datapath_clk_en(datapath_clk_en),
        .bus_abort_latched_n(bus_abort_latched_n));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t address %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t flags %b expected %b", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one microword per cycle; expectation from a shadow address and stack
    task automatic step(input logic [2:0] bc, input logic [ADDR_W-1:0] next_addr_field, input logic t);
        logic [ADDR_W-1:0] nxt;
        @(posedge ref_clk);
        word <= {seed[7:0], next_addr_field, seed[10:8], bc, 1'b0, seed[31:16]};
        test_bit <= t;
        @(negedge ref_clk);
        if (pend)
            chk_addr(micro_addr_out, exp_pend);
        cur = pend ? exp_pend : micro_addr_out;
        nxt = next_addr_field;
        if (bc == BC_INC || ((bc == BC_JT || bc == BC_JF) && (t == bc[0])))
            nxt = cur + 9'h001;
        if (bc == BC_CALL)
        begin
            for (int i = 3; i > 0; i--)
                stk[i] = stk[i - 1];
            stk[0] = cur + 9'h001;
        end
        if (bc == BC_RET || (bc == BC_RT && t) || (bc == BC_RF && !t))
        begin
            nxt = stk[0];
            for (int i = 0; i < 3; i++)
                stk[i] = stk[i + 1];
        end
        exp_pend = nxt;
        pend = 1'b1;
    endtask

    // trap from address 155, then return to it
    task automatic trap(input int idx, input logic rd, input logic [2:0] a,
        input logic [ADDR_W-1:0] vec, input logic [2:0] prio);
        int n;
        logic s;
        s = (idx == 6);
        @(posedge ref_clk);
        word <= {8'h00, 9'h155, 3'h0, BC_JMP, 1'b1, 16'h0000};
        @(negedge ref_clk);
        if (pend)
            chk_addr(micro_addr_out, exp_pend);
        partner.pulse(idx, rd, a);
        n = 0;
        while (datapath_clk_en !== 1'b0 && n < 8)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk_code({slave_active, irq_trap_n, datapath_clk_en}, {s, s, 1'b0});
        chk_code(irq_priority_code, prio);
        @(posedge ref_clk);
        word <= {8'h00, 9'h000, 3'h0, BC_RET, 1'b1, 16'h0000};
        @(negedge ref_clk);
        chk_addr(micro_addr_out, vec);
        chk_code({2'b00, datapath_clk_en}, 3'h1);
        @(posedge ref_clk);
        word <= {8'h00, 9'h155, 3'h0, BC_JMP, 1'b0, 16'h0000};
        @(negedge ref_clk);
        chk_addr(micro_addr_out, 9'h155);
        stk[3] = stk[2];
        pend = 1'b0;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        chk_addr(micro_addr_out, 9'h000);
        chk_code(irq_priority_code, PRIO_IDLE);
        arst_n <= 1'b1;
        repeat (300)
        begin
            v = xs();
            step(v[2:0], v[11:3], v[12]);
        end
        step(BC_JMP, 9'h1FF, 1'b0);
        step(BC_INC, 9'h0AA, 1'b1);
        for (int i = 0; i < 5; i++)
            step(BC_CALL, 9'(i * 37), 1'b0);
        for (int i = 0; i < 6; i++)
            step(BC_RET, 9'h033, 1'b0);
        $display("test branch codes done");
        for (int i = 0; i < 6; i++)
            trap(i, 1'b0, 3'h0, {2'b00, 3'(i < 2 ? 0 : i - 1), 4'h0}, 3'(i < 2 ? 0 : i - 1));
        $display("test interrupt traps done");
        for (int i = 0; i < 4; i++)
        begin
            v = xs();
            v[2:0] = i < 2 ? {3{v[0] ^ v[1]}} : v[2:0];
            trap(6, v[0], v[2:0], {2'b01, 3'h7, ~v[0], v[2:0]}, 3'h7);
        end
        $display("test slave traps done");
        @(posedge ref_clk);
        partner.pulse(6, 1'b1, 3'h3);
        v = 0;
        while (slave_reject !== 1'b1 && v < 8)
        begin
            @(negedge ref_clk);
            v[8] = v[8] | (datapath_clk_en !== 1'b1);
            v++;
        end
        chk_code({v[8], slave_reject, datapath_clk_en}, 3'h3);
        $display("test slave reject done");
        @(negedge ref_clk);
        #2 power_reset_n = 1'b0;
        #1 chk_addr(micro_addr_out, 9'h000);
        @(posedge ref_clk);
        power_reset_n <= 1'b1;
        v = 0;
        while (bus_abort_latched_n !== 1'b0 && v < 8)
        begin
            @(negedge ref_clk);
            v++;
        end
        chk_code({2'b00, bus_abort_latched_n}, 3'h0);
        $display("test power reset done");
        end_of_test();
    end
endmodule
